/* logic/ivte_prio.sv */
// level arbiter: picks the highest-level request among all nodes
`timescale 1ns/1ps
module ivte_prio (
    input wire logic [ivte_pkg::NODE_CNT-1:0] req,
    input wire logic [ivte_pkg::NODE_CNT*4-1:0] lvl_flat,
    output logic win_valid,
    output logic [6:0] win_idx,
    output logic [3:0] win_lvl
);
    // ------------------------------------------------------------
    // compare chain
    // ------------------------------------------------------------
    // chain of best-so-far; a long chain trades depth for area
    logic [ivte_pkg::NODE_CNT:0] bv;                  // chain valid
    logic [6:0] bi [ivte_pkg::NODE_CNT+1];            // chain index
    logic [3:0] bl [ivte_pkg::NODE_CNT+1];            // chain level

    assign bv[0] = 1'b0;
    assign bi[0] = 7'h00;
    assign bl[0] = 4'h0;

    genvar i;
    generate
        for (i = 0; i < ivte_pkg::NODE_CNT; i++) begin : g_stage
            wire [3:0] lv = lvl_flat[i*4 +: 4];
            // strictly higher wins, so lower index keeps ties
            wire take = req[i] && (!bv[i] || lv > bl[i]);
            assign bv[i+1] = bv[i] || req[i];
            assign bi[i+1] = take ? 7'(i) : bi[i];
            assign bl[i+1] = take ? lv : bl[i];
        end
    endgenerate

    assign win_valid = bv[ivte_pkg::NODE_CNT];
    assign win_idx = bi[ivte_pkg::NODE_CNT];
    assign win_lvl = bl[ivte_pkg::NODE_CNT];
endmodule

/* logic/ivte_top.sv */
// interrupt vector and trap entry engine with apb register slave
`timescale 1ns/1ps
module ivte_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ivte_pkg::NODE_CNT-1:0] node_req,
    input wire logic subch_end,
    input wire logic [ivte_pkg::TRAP_CNT-1:0] trap_evt,
    input wire logic [3:0] cpu_level,
    input wire logic vec_ack,
    input wire logic trap_done,
    output ivte_pkg::ivte_vec_t vec,
    output logic vec_valid,
    output logic pec_req,
    output logic [6:0] pec_node,
    output logic [ivte_pkg::TRAP_CNT-1:0] trap_flags
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [ivte_pkg::SEG_W-1:0] seg_reg;          // vector_table_segment
    logic [ivte_pkg::SPC_W-1:0] spc_reg;          // vector_spacing_field
    logic [ivte_pkg::TRAP_CNT-1:0] tflag_reg;     // trap_flag_register
    logic [ivte_pkg::TRAP_CNT-1:0] tpend_reg;     // traps awaiting entry
    logic [1:0] tlvl_reg;                         // trap in service, 0 none
    logic [3:0] ilvl_reg [ivte_pkg::NODE_CNT];    // node levels
    logic [ivte_pkg::NODE_CNT-1:0] ie_reg;        // node enables
    logic [ivte_pkg::NODE_CNT-1:0] ir_reg;        // node_request_bit
    logic [ivte_pkg::NODE_CNT-1:0] pecsel_reg;    // transfer routing
    ivte_pkg::ivte_state_t state_reg;
    ivte_pkg::ivte_vec_t vec_reg;
    logic vec_valid_reg;
    logic [6:0] src_reg;                          // node or trap bit offered
    logic pec_req_reg;
    logic [6:0] pec_node_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel && penable;
    wire fire = acc && pready_reg;                // completing edge
    wire wr_fire = fire && pwrite;
    wire hit_seg = paddr == ivte_pkg::SEG_OFF;
    wire hit_cfg = paddr == ivte_pkg::CFG_OFF;
    wire hit_tfr = paddr == ivte_pkg::TFR_OFF;
    wire hit_stat = paddr == ivte_pkg::STAT_OFF;
    wire hit_node = paddr >= ivte_pkg::NODE_OFF && paddr < ivte_pkg::NODE_END
        && paddr[1:0] == 2'h0;
    wire [11:0] node_rel = paddr - ivte_pkg::NODE_OFF;
    wire [6:0] node_idx = node_rel[8:2];
    wire mapped = hit_seg || hit_cfg || hit_tfr || hit_stat || hit_node;
    wire [31:0] node_word = {23'h00_0000, pecsel_reg[node_idx], ir_reg[node_idx],
        ie_reg[node_idx], 2'h0, ilvl_reg[node_idx]};
    wire [31:0] rd_mux =
        hit_seg ? {24'h00_0000, seg_reg} :
        hit_cfg ? {30'h0000_0000, spc_reg} :
        hit_tfr ? {24'h00_0000, tflag_reg} :
        hit_stat ? {28'h000_0000, tlvl_reg, vec_valid_reg, state_reg} :
        hit_node ? node_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [ivte_pkg::NODE_CNT*4-1:0] lvl_flat;   // levels for the arbiter
    logic [ivte_pkg::NODE_CNT-1:0] node_ok;      // requests above cpu level
    logic int_valid;
    logic [6:0] int_idx;
    logic [3:0] int_lvl;

    genvar g;
    generate
        for (g = 0; g < ivte_pkg::NODE_CNT; g++) begin : g_lvl
            assign lvl_flat[g*4 +: 4] = ilvl_reg[g];
            assign node_ok[g] = ir_reg[g] && ie_reg[g] && ilvl_reg[g] > cpu_level;
        end
    endgenerate

    ivte_prio u_prio (
        .req(node_ok),
        .lvl_flat(lvl_flat),
        .win_valid(int_valid),
        .win_idx(int_idx),
        .win_lvl(int_lvl)
    );

    wire int_go = int_valid && tlvl_reg == 2'h0;
    wire int_pec = pecsel_reg[int_idx];

    logic trap_go;            // some pending trap may enter
    logic [2:0] trap_bit;     // chosen flag position
    logic [1:0] trap_best;    // its priority
    always_comb begin
        trap_go = 1'b0;
        trap_bit = 3'h0;
        trap_best = 2'h0;
        for (int k = 0; k < ivte_pkg::TRAP_CNT; k++) begin
            if (tpend_reg[k] && ivte_pkg::trap_prio(k) > tlvl_reg
                && ivte_pkg::trap_prio(k) > trap_best) begin
                trap_go = 1'b1;
                trap_bit = 3'(k);
                trap_best = ivte_pkg::trap_prio(k);
            end
        end
    end

    // ------------------------------------------------------------
    // vector formation
    // ------------------------------------------------------------
    // number scaled by spacing
    function automatic logic [15:0] vec_off(input logic [6:0] num, input logic [1:0] spc);
        vec_off = {9'h000, num} << (ivte_pkg::SPC_SHIFT0 + {1'b0, spc});
    endfunction

    logic [7:0] tnum_lut [ivte_pkg::TRAP_CNT];   // trap numbers by flag
    generate
        for (g = 0; g < ivte_pkg::TRAP_CNT; g++) begin : g_tnum
            assign tnum_lut[g] = {1'b0, ivte_pkg::trap_num(g)};
        end
    endgenerate

    wire [6:0] int_num = ivte_pkg::NODE_BASE + int_idx;
    wire [6:0] trap_n = tnum_lut[trap_bit][6:0];
    wire [23:0] int_addr = {seg_reg, vec_off(int_num, spc_reg)};
    wire [23:0] trap_addr = {seg_reg, vec_off(trap_n, spc_reg)};

    // ------------------------------------------------------------
    // offer state machine controls
    // ------------------------------------------------------------
    wire idle = state_reg == ivte_pkg::ST_IDLE;
    wire load_trap = idle && trap_go;
    wire load_int = idle && !trap_go && int_go && !int_pec;
    wire pec_fire = idle && !trap_go && int_go && int_pec;
    wire offer = state_reg == ivte_pkg::ST_OFFER;
    wire acked = offer && vec_ack;
    // a node offer is withdrawn once a trap or a lost request overtakes it
    wire withdraw = offer && !vec_ack && !vec_reg.is_trap
        && (trap_go || !node_ok[src_reg] || tlvl_reg != 2'h0);
    wire node_clr = (acked && !vec_reg.is_trap) || pec_fire;
    wire [6:0] clr_idx = pec_fire ? int_idx : src_reg;

    // ------------------------------------------------------------
    // apb slave: one wait state, then pready for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            if (acc && !pready_reg) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // configuration words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_reg <= ivte_pkg::SEG_RST;
            spc_reg <= ivte_pkg::SPC_RST;
        end else if (ce && wr_fire) begin
            if (hit_seg) begin
                seg_reg <= pwdata[ivte_pkg::SEG_W-1:0];
            end
            if (hit_cfg) begin
                spc_reg <= pwdata[ivte_pkg::SPC_LSB +: ivte_pkg::SPC_W];
            end
        end
    end

    // ------------------------------------------------------------
    // per-node control and request bits
    // ------------------------------------------------------------
    generate
        for (g = 0; g < ivte_pkg::NODE_CNT; g++) begin : g_node
            localparam bit ASG = ivte_pkg::node_is_assigned(g);
            wire sw_hit = wr_fire && hit_node && node_idx == 7'(g);
            wire hw_set = ASG ? node_req[g] : 1'b0;
            wire sub_set = (g == ivte_pkg::SUBCH_IDX) ? subch_end : 1'b0;
            wire sw_set = sw_hit && pwdata[ivte_pkg::IR_BIT];
            wire clr = (sw_hit && !pwdata[ivte_pkg::IR_BIT]) || (node_clr && clr_idx == 7'(g));
            // set wins over clear
            wire ir_next = hw_set || sub_set || sw_set || (ir_reg[g] && !clr);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ir_reg[g] <= 1'b0;
                    ie_reg[g] <= 1'b0;
                    pecsel_reg[g] <= 1'b0;
                    ilvl_reg[g] <= ivte_pkg::LVL_RST;
                end else if (ce) begin
                    ir_reg[g] <= ir_next;
                    if (sw_hit) begin
                        ie_reg[g] <= pwdata[ivte_pkg::IE_BIT];
                        pecsel_reg[g] <= pwdata[ivte_pkg::PEC_BIT];
                        ilvl_reg[g] <= pwdata[ivte_pkg::LVL_LSB +: ivte_pkg::LVL_W];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // trap flags and pending traps
    // ------------------------------------------------------------
    wire tfr_clr = wr_fire && hit_tfr;
    wire [7:0] tpend_clr = (acked && vec_reg.is_trap) ? (8'h01 << src_reg[2:0]) : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tflag_reg <= 8'h00;
            tpend_reg <= 8'h00;
        end else if (ce) begin
            // own flag, set beats write-one clear
            tflag_reg <= trap_evt | (tflag_reg & ~(tfr_clr ? pwdata[7:0] : 8'h00));
            tpend_reg <= trap_evt | (tpend_reg & ~tpend_clr);
        end
    end

    // trap service level, held until the core reports completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tlvl_reg <= 2'h0;
        end else if (ce) begin
            if (acked && vec_reg.is_trap) begin
                tlvl_reg <= ivte_pkg::trap_prio(int'(src_reg[2:0]));
            end else if (trap_done) begin
                // nesting depth is one: an outer trap level is not restored
                tlvl_reg <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // offer state machine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ivte_pkg::ST_IDLE;
            vec_reg <= '0;
            vec_valid_reg <= 1'b0;
            src_reg <= 7'h00;
            pec_req_reg <= 1'b0;
            pec_node_reg <= 7'h00;
        end else if (ce) begin
            pec_req_reg <= pec_fire;
            unique case (state_reg)
                ivte_pkg::ST_IDLE: begin
                    if (load_trap) begin
                        vec_reg <= '{is_trap: 1'b1, num: trap_n, addr: trap_addr};
                        src_reg <= {4'h0, trap_bit};
                        vec_valid_reg <= 1'b1;
                        state_reg <= ivte_pkg::ST_OFFER;
                    end else if (load_int) begin
                        vec_reg <= '{is_trap: 1'b0, num: int_num, addr: int_addr};
                        src_reg <= int_idx;
                        vec_valid_reg <= 1'b1;
                        state_reg <= ivte_pkg::ST_OFFER;
                    end else if (pec_fire) begin
                        // one stolen cycle, no vector
                        pec_node_reg <= int_idx;
                    end
                end
                ivte_pkg::ST_OFFER: begin
                    if (acked || withdraw) begin
                        vec_valid_reg <= 1'b0;
                        state_reg <= ivte_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign vec = vec_reg;
    assign vec_valid = vec_valid_reg;
    assign pec_req = pec_req_reg;
    assign pec_node = pec_node_reg;
    assign trap_flags = tflag_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_node_write;
        psel && penable && pready_reg && pwrite && hit_node;
    endsequence
    sequence s_apb_wait;
        psel && penable && !pready_reg;
    endsequence

    a_trap_flag_set: assert property ((trap_evt != 8'h00) |=>
        (tflag_reg & $past(trap_evt)) == $past(trap_evt)) else $error("trap flag not set");
    a_seg_upper: assert property ($rose(vec_valid_reg) |->
        vec_reg.addr[23:16] == $past(seg_reg)) else $error("segment missing in vector");
    a_spacing_scale: assert property ($rose(vec_valid_reg) |->
        vec_reg.addr[15:0] == vec_off(vec_reg.num, $past(spc_reg)))
        else $error("offset not scaled by spacing");
    a_capture_reload_register_slot: assert property (vec_valid_reg && vec_reg.num == ivte_pkg::CAPTURE_RELOAD_REGISTER_NUM
        && spc_reg == ivte_pkg::SPC_RST |-> vec_reg.addr[15:0] == ivte_pkg::CAPTURE_RELOAD_REGISTER_OFF)
        else $error("capture node offset wrong");
    a_trap_first: assert property (idle && trap_go && int_go |=>
        vec_valid_reg && vec_reg.is_trap) else $error("trap lost to node");
    a_trap_above: assert property ($rose(vec_valid_reg) && vec_reg.is_trap |->
        ivte_pkg::trap_prio(int'(vec_reg.num == 7'h02 ? 0 : 4)) >= 2'h1
        && $past(tlvl_reg) < $past(trap_best)) else $error("trap entered under higher trap");
    a_no_node_in_trap: assert property (tlvl_reg != 2'h0 |=>
        !$rose(vec_valid_reg && !vec_reg.is_trap) && !pec_req_reg)
        else $error("node served during trap");
    a_level_beats: assert property ($rose(vec_valid_reg) && !vec_reg.is_trap |->
        ilvl_reg[src_reg] > $past(cpu_level)) else $error("node level not above cpu");
    a_sw_request: assert property (s_node_write ##0 pwdata[ivte_pkg::IR_BIT] |=>
        ir_reg[$past(node_idx)] || $past(node_clr)) else $error("software request lost");
    a_subch_node: assert property (subch_end |=> ir_reg[ivte_pkg::SUBCH_IDX])
        else $error("subchannel end node not raised");
    a_apb_ready: assert property (s_apb_wait |=> pready_reg ##1 !pready_reg)
        else $error("apb answer timing wrong");
endmodule

/* shared/ivte_pkg.sv */
// shared constants, types and lookups for the interrupt vector and trap entry block
package ivte_pkg;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] SEG_OFF = 12'h000;   // vector_table_segment
    localparam logic [11:0] CFG_OFF = 12'h004;   // cpu_config_register_one
    localparam logic [11:0] TFR_OFF = 12'h008;   // trap_flag_register
    localparam logic [11:0] STAT_OFF = 12'h00C;  // engine status, read only
    localparam logic [11:0] NODE_OFF = 12'h100;  // first node control word
    localparam logic [11:0] NODE_END = 12'h240;  // one past last node word

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int SEG_W = 8;           // segment width
    localparam int SPC_LSB = 0;         // vector_spacing_field position
    localparam int SPC_W = 2;           // 0:4 1:8 2:16 3:32 bytes
    localparam int LVL_LSB = 0;         // node priority level field
    localparam int LVL_W = 4;           // sixteen levels
    localparam int IE_BIT = 6;          // node enable
    localparam int IR_BIT = 7;          // node_request_bit
    localparam int PEC_BIT = 8;         // route node to peripheral_event_transfer
    localparam int TRAP_CNT = 8;        // hardware trap sources

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SEG_W-1:0] SEG_RST = 8'h00;
    localparam logic [SPC_W-1:0] SPC_RST = 2'h0;  // four bytes between vectors
    localparam logic [3:0] LVL_RST = 4'h0;

    // ------------------------------------------------------------
    // node numbering: node index i carries trap number 10h + i
    // ------------------------------------------------------------
    localparam int NODE_CNT = 80;
    localparam logic [6:0] NODE_BASE = 7'h10;
    localparam int SUBCH_IDX = 60;                // trap 4Ch
    localparam logic [6:0] CAPTURE_RELOAD_REGISTER_NUM = 7'h27;    // capture_reload_register node
    localparam logic [15:0] CAPTURE_RELOAD_REGISTER_OFF = 16'h009C;
    localparam logic [2:0] SPC_SHIFT0 = 3'h2;     // log2 of four bytes

    // trap flag bit positions
    localparam int T_NMI = 0;
    localparam int T_STKOF = 1;
    localparam int T_STKUF = 2;
    localparam int T_BRK = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic is_trap;       // trap entry, not a node
        logic [6:0] num;     // trap number
        logic [23:0] addr;   // segment and offset
    } ivte_vec_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_OFFER = 1'b1
    } ivte_state_t;

    // nodes with no peripheral behind them take software requests only
    function automatic bit node_is_assigned(input int idx);
        return !((idx <= 7) || (idx >= 14 && idx <= 17) || (idx >= 47 && idx <= 49)
            || (idx == 59) || (idx >= 68 && idx <= 76));
    endfunction

    // trap number per flag: class a traps own vectors, class b shares one
    function automatic logic [6:0] trap_num(input int bit_idx);
        case (bit_idx)
            T_NMI: return 7'h02;
            T_STKOF: return 7'h04;
            T_STKUF: return 7'h06;
            T_BRK: return 7'h08;
            default: return 7'h0A;
        endcase
    endfunction

    // trap priority, 3 highest; 0 means no trap in service
    function automatic logic [1:0] trap_prio(input int bit_idx);
        case (bit_idx)
            T_NMI: return 2'h3;
            T_STKOF, T_STKUF: return 2'h2;
            default: return 2'h1;
        endcase
    endfunction

endpackage

/* tb/ivte_core_model.sv */
// core model: takes each offered vector after a chosen delay
`timescale 1ns/1ps
module ivte_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vec_valid,
    input wire logic [3:0] dly,
    output logic vec_ack
);
    logic [3:0] wait_reg; // cycles the offer has stood so far
    // ack once the offer stood dly+1 cycles, then let go at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
            vec_ack <= 1'b0;
        end else if (vec_valid && !vec_ack) begin
            wait_reg <= wait_reg + 4'h1;
            vec_ack <= (wait_reg >= dly);
        end else begin
            wait_reg <= 4'h0;
            vec_ack <= 1'b0;
        end
    end
endmodule

/* tb/testbench.sv */
// self-checking bench for the vector and trap entry engine
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, subch_end, vec_ack, trap_done;
    logic pready, pslverr, vec_valid, err, hit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [ivte_pkg::NODE_CNT-1:0] node_req;
    logic [ivte_pkg::TRAP_CNT-1:0] trap_evt, trap_flags;
    logic [3:0] cpu_level, dly;
    ivte_pkg::ivte_vec_t vec;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    ivte_top uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .node_req(node_req),
        .subch_end(subch_end), .trap_evt(trap_evt), .cpu_level(cpu_level),
        .vec_ack(vec_ack), .trap_done(trap_done), .vec(vec), .vec_valid(vec_valid),
        .pec_req(), .pec_node(), .trap_flags(trap_flags));
    ivte_core_model core (.pclk(pclk), .presetn(presetn), .vec_valid(vec_valid),
        .dly(dly), .vec_ack(vec_ack));
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // apb cycle: hold the request until pready, take data in that cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // sample pready at the rising edge; the request stands until then
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bounded look for an offer; hit stays low if none came
    task automatic wait_vec(output logic got);
        got = 1'b0;
        for (int k = 0; k < 20 && !got; k++) begin
            @(posedge pclk);
            got = vec_valid;
        end
    endtask
    // check the offer, then let the core take it so no stale offer remains
    task automatic expect_vec(input logic [31:0] exp);
        wait_vec(hit);
        chk({31'h0, hit}, 32'h0000_0001);
        chk(vec, exp);
        for (int k = 0; k < 20 && vec_valid; k++) begin
            @(posedge pclk);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, subch_end, trap_done} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        node_req = '0;
        trap_evt = '0;
        cpu_level = 4'hF;
        dly = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ivte_pkg::CFG_OFF, 32'h0); chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0); chk({31'h0, err}, 32'h0000_0001);
        // level 15 node against cpu level 15 must stay quiet
        apb(1'b1, 12'h15C, 32'h0000_004F);
        node_req[23] <= 1'b1;
        @(posedge pclk);
        node_req[23] <= 1'b0;
        wait_vec(hit); chk({31'h0, hit}, 32'h0000_0000);
        cpu_level <= 4'h0;
        expect_vec({1'b0, 7'h27, 24'h00_009C});
        dly <= 4'h3;
        apb(1'b1, 12'h1F0, 32'h0000_004F);
        subch_end <= 1'b1;
        @(posedge pclk);
        subch_end <= 1'b0;
        expect_vec({1'b0, 7'h4C, 24'h00_0130});
        trap_evt[1] <= 1'b1;
        @(posedge pclk);
        trap_evt[1] <= 1'b0;
        expect_vec({1'b1, 7'h04, 24'h00_0010});
        apb(1'b1, 12'h100, 32'h0000_00CF);
        wait_vec(hit); chk({31'h0, hit}, 32'h0000_0000);
        trap_evt[0] <= 1'b1;
        @(posedge pclk);
        trap_evt[0] <= 1'b0;
        expect_vec({1'b1, 7'h02, 24'h00_0008});
        apb(1'b0, ivte_pkg::TFR_OFF, 32'h0); chk(rd, 32'h0000_0003);
        chk({24'h0, trap_flags}, 32'h0000_0003);
        trap_done <= 1'b1;
        @(posedge pclk);
        trap_done <= 1'b0;
        expect_vec({1'b0, 7'h10, 24'h00_0040});
        apb(1'b1, ivte_pkg::SEG_OFF, 32'h0000_005A);
        apb(1'b1, ivte_pkg::CFG_OFF, 32'h0000_0001);
        apb(1'b1, 12'h100, 32'h0000_00CF);
        expect_vec({1'b0, 7'h10, 24'h5A_0080});
        finish_test;
    end
endmodule
